// >>> inc/inertial_output_pkg.sv
// Package for the inertial output register set: offsets, scales, types
package inertial_output_pkg;
	// Byte address of each register (low byte of the pair)
	localparam logic [6:0] RATE_X_LOW_ADDR = 7'h04;
	localparam logic [6:0] RATE_X_HIGH_ADDR = 7'h06;
	localparam logic [6:0] RATE_Y_LOW_ADDR = 7'h08;
	localparam logic [6:0] RATE_Y_HIGH_ADDR = 7'h0a;
	localparam logic [6:0] RATE_Z_LOW_ADDR = 7'h0c;
	localparam logic [6:0] RATE_Z_HIGH_ADDR = 7'h0e;
	localparam logic [6:0] ACCEL_X_LOW_ADDR = 7'h10;
	localparam logic [6:0] ACCEL_X_HIGH_ADDR = 7'h12;
	localparam logic [6:0] ACCEL_Y_LOW_ADDR = 7'h14;
	localparam logic [6:0] ACCEL_Y_HIGH_ADDR = 7'h16;
	localparam logic [6:0] ACCEL_Z_LOW_ADDR = 7'h18;
	localparam logic [6:0] ACCEL_Z_HIGH_ADDR = 7'h1a;
	// First and last byte of the output block, and per-axis stride
	localparam logic [6:0] BLOCK_BASE_ADDR = 7'h04;
	localparam logic [6:0] BLOCK_LAST_ADDR = 7'h1b;
	localparam logic [6:0] AXIS_STRIDE = 7'h04;
	localparam logic [6:0] ACCEL_BASE_ADDR = 7'h10;
	// Rate scale factors in counts per degree per second, by model range
	localparam int RATE_SCALE_NARROW = 160;
	localparam int RATE_SCALE_MEDIUM = 40;
	localparam int RATE_SCALE_WIDE = 10;
	// Acceleration high word limits, plus and minus 32000 counts
	localparam logic [15:0] ACCEL_FULL_POS = 16'h7d00;
	localparam logic [15:0] ACCEL_FULL_NEG = 16'h8300;
	// Value held before the first sample arrives
	localparam logic [31:0] SAMPLE_RESET = 32'h0000_0000;
	localparam logic [15:0] READ_UNMAPPED = 16'h0000;
	localparam int AXIS_COUNT = 3;

	// One 32-bit twos complement measurement: high word above low word
	typedef struct packed {
		logic [15:0] high;
		logic [15:0] low;
	} axis_word_t;

	// One full sample: three rate axes then three acceleration axes
	typedef struct packed {
		axis_word_t [AXIS_COUNT-1:0] rate;
		axis_word_t [AXIS_COUNT-1:0] accel;
	} imu_sample_t;
endpackage

// >>> hw/inertial_output_registers.sv
// Read-only register set holding the latest angular rate and acceleration sample
`timescale 1ns/10ps
module inertial_output_registers
	import inertial_output_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sampleValid,
	input wire imu_sample_t sampleIn,
	input wire logic readStrobe,
	input wire logic [6:0] readAddr,
	input wire logic writeStrobe,
	output logic [15:0] readData,
	output logic readValid,
	output logic readHit
);
	imu_sample_t sample_reg;
	logic [15:0] readData_reg;
	logic [15:0] readData_next;
	logic readValid_reg;
	logic readHit_reg;
	logic readHit_next;
	logic [6:0] rel;
	logic [1:0] axisIdx;
	logic isAccel;
	logic [15:0] clampHigh [AXIS_COUNT];

	// Clamp acceleration high words to the documented full scale
	genvar g;
	generate
		for (g = 0; g < AXIS_COUNT; g++)
		begin : gClamp
			always_comb
			begin
				if ($signed(sampleIn.accel[g].high) > $signed(ACCEL_FULL_POS))
					clampHigh[g] = ACCEL_FULL_POS;
				else if ($signed(sampleIn.accel[g].high) < $signed(ACCEL_FULL_NEG))
					clampHigh[g] = ACCEL_FULL_NEG;
				else
					clampHigh[g] = sampleIn.accel[g].high;
			end
		end
	endgenerate

	// Whole sample captured in one edge so high and low words always pair
	always_ff @(posedge clk)
	begin
		if (rst)
			sample_reg <= {(2 * AXIS_COUNT){SAMPLE_RESET}};
		else if (sampleValid)
		begin
			sample_reg.rate <= sampleIn.rate;
			for (int i = 0; i < AXIS_COUNT; i++)
			begin
				sample_reg.accel[i].high <= clampHigh[i];
				sample_reg.accel[i].low <= sampleIn.accel[i].low;
			end
		end
	end

	// Address decode: axis by 4-byte stride, odd bit ignored, bit 1 picks high word
	always_comb
	begin
		isAccel = (readAddr >= ACCEL_BASE_ADDR);
		rel = isAccel ? (readAddr - ACCEL_BASE_ADDR) : (readAddr - BLOCK_BASE_ADDR);
		axisIdx = rel[3:2];
		readHit_next = (readAddr >= BLOCK_BASE_ADDR) && (readAddr <= BLOCK_LAST_ADDR);
		readData_next = READ_UNMAPPED;
		if (readHit_next)
		begin
			if (isAccel)
				readData_next = rel[1] ? sample_reg.accel[axisIdx].high : sample_reg.accel[axisIdx].low;
			else
				readData_next = rel[1] ? sample_reg.rate[axisIdx].high : sample_reg.rate[axisIdx].low;
		end
	end

	// Read answer registered one cycle after the strobe; writes are ignored
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			readData_reg <= READ_UNMAPPED;
			readValid_reg <= 1'b0;
			readHit_reg <= 1'b0;
		end
		else
		begin
			readValid_reg <= readStrobe;
			if (readStrobe)
			begin
				readData_reg <= readData_next;
				readHit_reg <= readHit_next;
			end
		end
	end

	assign readData = readData_reg;
	assign readValid = readValid_reg;
	assign readHit = readHit_reg;

	// Assertions
	// Every strobe is answered on the next edge
	a_read_latency: assert property (@(posedge clk) disable iff (rst)
		readStrobe
		|=> readValid)
		else $error("read answer missing");

	// No answer appears without a strobe
	a_read_single: assert property (@(posedge clk) disable iff (rst)
		!readStrobe
		|=> !readValid)
		else $error("read answer without strobe");

	// Rate x low word at its byte pair
	a_rate_x_low: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == RATE_X_LOW_ADDR && !sampleValid)
		|=> readData == sample_reg.rate[0].low)
		else $error("rate x low wrong");

	// Rate x high word at its byte pair
	a_rate_x_high: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == RATE_X_HIGH_ADDR && !sampleValid)
		|=> readData == sample_reg.rate[0].high)
		else $error("rate x high wrong");

	// Odd byte of a pair reads the same word
	a_rate_x_odd: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == (RATE_X_HIGH_ADDR | 7'h01) && !sampleValid)
		|=> readData == sample_reg.rate[0].high)
		else $error("rate x high odd byte wrong");

	// Rate y low word
	a_rate_y_low: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == RATE_Y_LOW_ADDR && !sampleValid)
		|=> readData == sample_reg.rate[1].low)
		else $error("rate y low wrong");

	// Rate y high word
	a_rate_y_high: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == RATE_Y_HIGH_ADDR && !sampleValid)
		|=> readData == sample_reg.rate[1].high)
		else $error("rate y high wrong");

	// Rate z low word
	a_rate_z_low: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == RATE_Z_LOW_ADDR && !sampleValid)
		|=> readData == sample_reg.rate[2].low)
		else $error("rate z low wrong");

	// Rate z high word
	a_rate_z_high: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == RATE_Z_HIGH_ADDR && !sampleValid)
		|=> readData == sample_reg.rate[2].high)
		else $error("rate z high wrong");

	// Accel x low word
	a_accel_x_low: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == ACCEL_X_LOW_ADDR && !sampleValid)
		|=> readData == sample_reg.accel[0].low)
		else $error("accel x low wrong");

	// Accel x high word
	a_accel_x_high: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == ACCEL_X_HIGH_ADDR && !sampleValid)
		|=> readData == sample_reg.accel[0].high)
		else $error("accel x high wrong");

	// Accel y low word
	a_accel_y_low: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == ACCEL_Y_LOW_ADDR && !sampleValid)
		|=> readData == sample_reg.accel[1].low)
		else $error("accel y low wrong");

	// Accel y high word
	a_accel_y_high: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == ACCEL_Y_HIGH_ADDR && !sampleValid)
		|=> readData == sample_reg.accel[1].high)
		else $error("accel y high wrong");

	// Accel z low word
	a_accel_z_low: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == ACCEL_Z_LOW_ADDR && !sampleValid)
		|=> readData == sample_reg.accel[2].low)
		else $error("accel z low wrong");

	// Accel z high word
	a_accel_z_high: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == ACCEL_Z_HIGH_ADDR && !sampleValid)
		|=> readData == sample_reg.accel[2].high)
		else $error("accel z high wrong");

	// Last byte of the block still reads accel z high
	a_accel_z_odd: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr == (ACCEL_Z_HIGH_ADDR | 7'h01) && !sampleValid)
		|=> readData == sample_reg.accel[2].high)
		else $error("accel z high odd byte wrong");

	// Addresses above the block read zero and miss
	a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr > BLOCK_LAST_ADDR)
		|=> (readData == READ_UNMAPPED && !readHit))
		else $error("unmapped read not zero");

	// Addresses below the block read zero and miss
	a_below_zero: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr < BLOCK_BASE_ADDR)
		|=> (readData == READ_UNMAPPED && !readHit))
		else $error("read below block not zero");

	// Addresses inside the block hit
	a_mapped_hit: assert property (@(posedge clk) disable iff (rst)
		(readStrobe && readAddr >= BLOCK_BASE_ADDR && readAddr <= BLOCK_LAST_ADDR)
		|=> readHit)
		else $error("mapped read missed");

	// Answer holds until the next strobe
	a_data_hold: assert property (@(posedge clk) disable iff (rst)
		!readStrobe
		|=> ($stable(readData) && $stable(readHit)))
		else $error("read answer changed without strobe");

	// Stored accel x stays within full scale
	a_accel_full_scale: assert property (@(posedge clk) disable iff (rst)
		$signed(sample_reg.accel[0].high) <= $signed(ACCEL_FULL_POS)
		&& $signed(sample_reg.accel[0].high) >= $signed(ACCEL_FULL_NEG))
		else $error("accel beyond full scale");

	// Stored accel y stays within full scale
	a_accel_y_scale: assert property (@(posedge clk) disable iff (rst)
		$signed(sample_reg.accel[1].high) <= $signed(ACCEL_FULL_POS)
		&& $signed(sample_reg.accel[1].high) >= $signed(ACCEL_FULL_NEG))
		else $error("accel y beyond full scale");

	// Stored accel z stays within full scale
	a_accel_z_scale: assert property (@(posedge clk) disable iff (rst)
		$signed(sample_reg.accel[2].high) <= $signed(ACCEL_FULL_POS)
		&& $signed(sample_reg.accel[2].high) >= $signed(ACCEL_FULL_NEG))
		else $error("accel z beyond full scale");

	// Positive overrange is stored as positive full scale
	a_clamp_pos: assert property (@(posedge clk) disable iff (rst)
		(sampleValid && $signed(sampleIn.accel[0].high) > $signed(ACCEL_FULL_POS))
		|=> sample_reg.accel[0].high == ACCEL_FULL_POS)
		else $error("positive overrange not clamped");

	// Negative overrange is stored as negative full scale
	a_clamp_neg: assert property (@(posedge clk) disable iff (rst)
		(sampleValid && $signed(sampleIn.accel[1].high) < $signed(ACCEL_FULL_NEG))
		|=> sample_reg.accel[1].high == ACCEL_FULL_NEG)
		else $error("negative overrange not clamped");

	// In-range accel passes unchanged
	a_accel_pass: assert property (@(posedge clk) disable iff (rst)
		(sampleValid && $signed(sampleIn.accel[2].high) <= $signed(ACCEL_FULL_POS)
		&& $signed(sampleIn.accel[2].high) >= $signed(ACCEL_FULL_NEG))
		|=> sample_reg.accel[2].high == $past(sampleIn.accel[2].high))
		else $error("in-range accel altered");

	// Rate x words are stored unaltered
	a_rate_capture: assert property (@(posedge clk) disable iff (rst)
		sampleValid
		|=> sample_reg.rate[0] == $past(sampleIn.rate[0]))
		else $error("rate x not captured");

	// Rate y and accel y low from one sample
	a_sample_pair: assert property (@(posedge clk) disable iff (rst)
		sampleValid
		|=> (sample_reg.rate[1] == $past(sampleIn.rate[1]) && sample_reg.accel[1].low == $past(sampleIn.accel[1].low)))
		else $error("words not updated together");

	// Rate z words from one sample
	a_rate_z_pair: assert property (@(posedge clk) disable iff (rst)
		sampleValid
		|=> sample_reg.rate[2] == $past(sampleIn.rate[2]))
		else $error("rate z not updated together");

	// Accel low words kept as delivered
	a_accel_low_keep: assert property (@(posedge clk) disable iff (rst)
		sampleValid
		|=> (sample_reg.accel[0].low == $past(sampleIn.accel[0].low) && sample_reg.accel[2].low == $past(sampleIn.accel[2].low)))
		else $error("accel low word altered");

	// Stored sample holds without a new one
	a_hold_no_sample: assert property (@(posedge clk) disable iff (rst)
		!sampleValid
		|=> $stable(sample_reg))
		else $error("sample changed without valid");

	// Write attempts leave the registers alone
	a_write_ignored: assert property (@(posedge clk) disable iff (rst)
		(writeStrobe && !sampleValid)
		|=> $stable(sample_reg))
		else $error("write changed a register");

	// Reset clears the read answer
	a_reset_clear: assert property (@(posedge clk)
		rst
		|=> (!readValid && readData == READ_UNMAPPED && !readHit))
		else $error("read answer not cleared by reset");

	// Reset clears the stored sample
	a_reset_sample: assert property (@(posedge clk)
		rst
		|=> sample_reg == {(2 * AXIS_COUNT){SAMPLE_RESET}})
		else $error("sample not cleared by reset");
endmodule

// >>> verification/host_model.sv
// Host side model that issues single-cycle register reads
`timescale 1ns/10ps
module host_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reqGo,
	input wire logic [6:0] reqAddr,
	output logic readStrobe,
	output logic [6:0] readAddr
);
	// One strobe per request; the address is scrambled once the strobe is gone
	always_ff @(posedge clk)
	begin
		readStrobe <= reqGo & ~rst;
		readAddr <= reqGo ? reqAddr : ~readAddr;
	end
endmodule

// >>> verification/inertial_output_registers_tb_top.sv
// Self-checking bench for the inertial output register set
`timescale 1ns/10ps
module inertial_output_registers_tb_top;
	import inertial_output_pkg::*;
	logic clk = 0, rst = 1, sampleValid = 0, writeStrobe = 0, reqGo = 0, readStrobe, readValid, readHit;
	logic [6:0] reqAddr = 0, readAddr;
	logic [15:0] readData;
	imu_sample_t sampleIn = '0, model = '0;
	int failures = 0, comparisons = 0;
	always #12.5 clk = ~clk;
	host_model i_host_model (.clk(clk), .rst(rst), .reqGo(reqGo), .reqAddr(reqAddr), .readStrobe(readStrobe),
		.readAddr(readAddr));
	inertial_output_registers i_inertial_output_registers (.clk(clk), .rst(rst), .sampleValid(sampleValid),
		.sampleIn(sampleIn), .readStrobe(readStrobe), .readAddr(readAddr), .writeStrobe(writeStrobe),
		.readData(readData), .readValid(readValid), .readHit(readHit));
	task automatic check(string what, logic [15:0] seen, logic [15:0] want);
		comparisons++;
		if (seen !== want)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Expected word: group by address, high word at offset 2, accel high clamped
	function automatic logic [15:0] expect_word(imu_sample_t s, logic [6:0] a);
		axis_word_t w;
		int g;
		logic [15:0] v;
		if (a < 7'h04 || a > 7'h1b)
			return 16'h0000;
		g = (a - 7'h04) >> 2;
		w = (g < 3) ? s.rate[g] : s.accel[g - 3];
		v = a[1] ? w.high : w.low;
		if (g >= 3 && a[1] && $signed(v) > $signed(ACCEL_FULL_POS))
			v = ACCEL_FULL_POS;
		if (g >= 3 && a[1] && $signed(v) < $signed(ACCEL_FULL_NEG))
			v = ACCEL_FULL_NEG;
		return v;
	endfunction
	task automatic rd(logic [6:0] a);
		int n;
		@(posedge clk);
		reqAddr <= a;
		reqGo <= 1'b1;
		@(posedge clk);
		reqGo <= 1'b0;
		for (n = 0; n < 4; n++)
		begin
			@(posedge clk);
			#1;
			if (readValid === 1'b1)
				break;
		end
		if (n == 4)
		begin
			failures++;
			conclude();
		end
		check("readData", readData, expect_word(model, a));
		check("readHit", {15'h0000, readHit}, {15'h0000, a >= 7'h04 && a <= 7'h1b});
	endtask
	task automatic load(imu_sample_t s);
		@(posedge clk);
		sampleIn <= s;
		sampleValid <= 1'b1;
		@(posedge clk);
		sampleValid <= 1'b0;
		model = s;
	endtask
	// Reset, then random and corner samples read back across the whole map
	initial
	begin
		imu_sample_t s;
		int k;
		void'($urandom(93));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(RATE_X_HIGH_ADDR);
		for (k = 0; k < 5; k++)
		begin
			s = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
			if (k == 1)
			begin
				s.accel[0].high = 16'h7fff;
				s.accel[1].high = 16'h8000;
				s.accel[2].high = ACCEL_FULL_NEG;
			end
			if (k == 2)
				s = '0;
			writeStrobe <= 1'($urandom());
			load(s);
			for (int a = 2; a < 32; a += 2)
				rd(7'(a) | 7'($urandom() % 2));
		end
		conclude();
	end
endmodule
